// File: testbench/dct_top_sva.sv
/* port assertions for dct_top, bound below.
   assumes selects stay put while an edge is in flight */
`timescale 1ns/1ps
module dct_top_sva (
    input wire logic       clock_i,
    input wire logic       reset_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic       port_alt_a_i,
    input wire logic       port_alt_b_i,
    input wire logic       port_combined_i,
    input wire logic       pin_alt_a_o,
    input wire logic       pin_alt_b_o,
    input wire logic       pin_combined_o,
    input wire logic       irq_a8_o,
    input wire logic       irq_b16_o,
    input wire logic       ext_irq_two_o
);
    logic [7:0] sa, sc, sb;
    logic [1:0] up;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    // shadows of written controls; up hides the edges right after reset
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sa <= 8'h00;
            sc <= 8'h00;
            sb <= 8'h00;
            up <= 2'h0;
        end else begin
            if (wr_i && addr_i == 4'h0) sa <= wdata_i;
            if (wr_i && addr_i == 4'h1) sc <= wdata_i;
            if (wr_i && addr_i == 4'h2) sb <= wdata_i;
            if (up != 2'h3) up <= up + 2'h1;
        end
    end
    sequence s_rd(a);
        rd_i && addr_i == a;
    endsequence
    sequence s_wb(b);
        wr_i && addr_i == 4'h2 && wdata_i[7] == b && !wdata_i[6];
    endsequence
    a_common_readback: assert property (
        wr_i && addr_i == 4'h1 && !wdata_i[7] && !sc[7]
        ##1 !wr_i ##1 s_rd(4'h1)
        |=> rdata_o == $past(wdata_i, 3)) else $error("ctl_common readback");
    a_run_reads_one: assert property (
        s_wb(1'b1) ##1 !wr_i ##1 s_rd(4'h2) |=> rdata_o[7])
        else $error("run bit not set");
    a_stop_reads_zero: assert property (
        s_wb(1'b0) ##1 !wr_i ##1 s_rd(4'h2) |=> !rdata_o[7])
        else $error("run bit not clear");
    a_combined_port: assert property (
        up == 2'h3 && !$past(sc[6])
        |-> pin_combined_o == $past(port_combined_i))
        else $error("combined pin not port data");
    a_alt_b_port: assert property (
        up == 2'h3 && !$past(sb[0]) |-> pin_alt_b_o == $past(port_alt_b_i))
        else $error("alt b pin not port data");
    a_alt_a_port: assert property (
        up == 2'h3 && !$past(sa[0]) |-> pin_alt_a_o == $past(port_alt_a_i))
        else $error("alt a pin not port data");
    a_ext_irq_src: assert property (
        ext_irq_two_o |-> $past(sc[7]) && !$past(sc[6]))
        else $error("ext irq source");
    a_b16_irq_en: assert property (
        irq_b16_o |-> $past(sb[2:1]) != 2'h0) else $error("b16 irq masked");
    a_a8_irq_en: assert property (
        irq_a8_o |-> $past(sa[2:1]) != 2'h0) else $error("a8 irq masked");
endmodule
bind dct_top dct_top_sva u_sva (.*);

// File: testbench/dct_top_tb_top.sv
/* self-checking bench for dct_top: register tasks and pin stimulus.
   assumes no partner model; bench drives every input */
`timescale 1ns/1ps
module dct_top_tb_top;
    logic       clock_i = 1'b0;
    logic       reset_n_i = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       inp = 1'b0;
    logic       ins = 1'b0;
    logic       pp = 1'b0;
    logic [7:0] rdata;
    logic       alt_a, alt_b, comb, irq_a, irq_b, irq_x;
    int         fails = 0, num_checks = 0, cyc = 0, na = 0, nb = 0, nx = 0;
    logic [7:0] tv [8] = '{8'h03, 8'h14, 8'h28, 8'h3c,
                           8'h08, 8'h10, 8'h18, 8'h05};
    dct_top u_dut (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .in_primary_i(inp), .in_secondary_i(ins), .port_alt_a_i(pp),
        .port_alt_b_i(pp), .port_combined_i(pp), .pin_alt_a_o(alt_a),
        .pin_alt_b_o(alt_b), .pin_combined_o(comb), .irq_a8_o(irq_a),
        .irq_b16_o(irq_b), .ext_irq_two_o(irq_x));
    initial begin
        forever #12.5 clock_i = ~clock_i;
    end
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock_i);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] m, e);
        @(posedge clock_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock_i);
        rd <= 1'b0;
        #1 chk("rdata", e, rdata & m);
    endtask
    // pulse counters and hang guard
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (irq_a === 1'b1) na <= na + 1;
        if (irq_b === 1'b1) nb <= nb + 1;
        if (irq_x === 1'b1) nx <= nx + 1;
        if (cyc == 20000) begin
            fails++;
            print_verdict();
        end
    end
    initial begin
        int k;
        repeat (6) @(posedge clock_i);
        reset_n_i <= 1'b1;
        for (int i = 0; i < 3; i++) rd_reg(i[3:0], 8'hff, 8'h00);
        rd_reg(4'ha, 8'hff, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr_reg(i < 4 ? 4'h1 : 4'h2, tv[i]);
            rd_reg(i < 4 ? 4'h1 : 4'h2, 8'hff, tv[i]);
        end
        wr_reg(4'h1, 8'h00);
        wr_reg(4'h2, 8'h00);
        pp <= 1'b1;
        repeat (3) @(posedge clock_i);
        chk("pins", 8'h07, {5'h0, alt_a, alt_b, comb});
        $display("test registers done");
        wr_reg(4'h3, 8'h03);
        wr_reg(4'h0, 8'h83);
        repeat (40) @(posedge clock_i);
        chk("a8 irq", 8'h01, {7'h0, na > 0});
        wr_reg(4'h0, 8'h81);
        repeat (4) @(posedge clock_i);
        k = na;
        repeat (40) @(posedge clock_i);
        chk("a8 masked", 8'h01, {7'h0, na == k});
        wr_reg(4'h0, 8'h00);
        wr_reg(4'h4, 8'h05);
        wr_reg(4'h2, 8'hc2);
        repeat (40) @(posedge clock_i);
        rd_reg(4'h2, 8'ha0, 8'h20);
        chk("b16 irq", 8'h01, {7'h0, nb > 0});
        wr_reg(4'h2, 8'h20);
        rd_reg(4'h2, 8'hff, 8'h00);
        wr_reg(4'h2, 8'h80);
        rd_reg(4'h2, 8'h80, 8'h80);
        repeat (40) @(posedge clock_i);
        rd_reg(4'h2, 8'h80, 8'h80);
        wr_reg(4'h2, 8'h20);
        $display("test timers done");
        wr_reg(4'h1, 8'h90);
        inp <= 1'b1;
        repeat (8) @(posedge clock_i);
        rd_reg(4'h1, 8'h03, 8'h02);
        chk("ext irq", 8'h01, {7'h0, nx > 0});
        wr_reg(4'h1, 8'ha3);
        rd_reg(4'h1, 8'h03, 8'h00);
        inp <= 1'b0;
        repeat (8) @(posedge clock_i);
        rd_reg(4'h1, 8'h03, 8'h01);
        wr_reg(4'h1, 8'hd3);
        k = nx;
        ins <= 1'b1;
        inp <= 1'b1;
        repeat (8) @(posedge clock_i);
        rd_reg(4'h1, 8'h03, 8'h02);
        chk("ext irq quiet", 8'h01, {7'h0, nx == k});
        // both inputs low so the filtered level starts low again
        inp <= 1'b0;
        ins <= 1'b0;
        repeat (10) @(posedge clock_i);
        wr_reg(4'h1, 8'h9b);
        // a five tick glitch must not pass the eight tick filter
        inp <= 1'b1;
        repeat (5) @(posedge clock_i);
        inp <= 1'b0;
        repeat (12) @(posedge clock_i);
        rd_reg(4'h1, 8'h03, 8'h00);
        inp <= 1'b1;
        repeat (14) @(posedge clock_i);
        rd_reg(4'h1, 8'h03, 8'h02);
        wr_reg(4'h4, 8'h02);
        wr_reg(4'h2, 8'h84);
        repeat (20) @(posedge clock_i);
        rd_reg(4'h2, 8'ha0, 8'ha0);
        // a rising edge long after the wrap captures a count near ffff
        inp <= 1'b0;
        repeat (10) @(posedge clock_i);
        k = nb;
        inp <= 1'b1;
        repeat (12) @(posedge clock_i);
        rd_reg(4'h7, 8'hff, 8'hff);
        chk("b16 cap irq", 8'h01, {7'h0, nb == k + 1});
        // armed: first edge captures, the second is ignored
        wr_reg(4'h2, 8'hc4);
        for (int j = 0; j < 2; j++) begin
            inp <= 1'b0;
            repeat (10) @(posedge clock_i);
            inp <= 1'b1;
            repeat (12) @(posedge clock_i);
        end
        chk("rearm irq", 8'h01, {7'h0, nb == k + 2});
        $display("test demodulation done");
        print_verdict();
    end
endmodule

// File: verilog/dct_edge.sv
/*
 * Glitch filter and edge detector for the demodulation input.
 * Assumes the input is synchronous to clock_i.
 */
`timescale 1ns/1ps
module dct_edge (
    input  wire logic       clock_i,
    input  wire logic       reset_n_i,
    input  wire logic       din_i,
    input  wire logic [1:0] filt_i,
    output logic            rise_o,
    output logic            fall_o
);
    import dct_pkg::*;

    logic       lvl;
    logic [3:0] cnt;
    logic       next_lvl;
    logic [3:0] next_cnt;
    logic       next_rise;
    logic       next_fall;
    logic [3:0] need;

    // a new level must hold for the filter length
    // filter length select
    always_comb begin
        need      = FILT_0_TICKS;
        next_lvl  = lvl;
        next_cnt  = 4'h0;
        next_rise = 1'b0;
        next_fall = 1'b0;
        if (filt_i == FILT_4) begin
            need = FILT_4_TICKS;
        end else if (filt_i == FILT_8) begin
            need = FILT_8_TICKS;
        end
        if (din_i != lvl) begin
            if (cnt + 4'h1 >= need) begin
                next_lvl  = din_i;
                next_rise = din_i;
                next_fall = ~din_i;
            end else begin
                next_cnt = cnt + 4'h1;
            end
        end
    end

    // filtered level, run length and edge pulses
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lvl    <= 1'b0;
            cnt    <= 4'h0;
            rise_o <= 1'b0;
            fall_o <= 1'b0;
        end else begin
            lvl    <= next_lvl;
            cnt    <= next_cnt;
            rise_o <= next_rise;
            fall_o <= next_fall;
        end
    end
endmodule

// File: verilog/dct_pkg.sv
/*
 * Constants for the dual counter control block: register offsets, field
 * positions, reset values, mode codes and glitch filter lengths.
 * Assumes an 8-bit register port with a 4-bit address.
 */
package dct_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [3:0] ADDR_CTL_A8      = 4'h0;
    localparam logic [3:0] ADDR_CTL_COMMON  = 4'h1;
    localparam logic [3:0] ADDR_CTL_B16     = 4'h2;
    localparam logic [3:0] ADDR_LOAD_A8     = 4'h3;
    localparam logic [3:0] ADDR_LOAD_B16_LO = 4'h4;
    localparam logic [3:0] ADDR_LOAD_B16_HI = 4'h5;
    localparam logic [3:0] ADDR_CAP_B16_LO  = 4'h6;
    localparam logic [3:0] ADDR_CAP_B16_HI  = 4'h7;
    localparam logic [3:0] ADDR_CAP_LOW     = 4'h8;
    localparam logic [3:0] ADDR_CAP_HIGH    = 4'h9;

    // shared bit positions of ctl_a8 and ctl_b16, CLK_LO in ctl_b16 only
    localparam int RUN_BIT     = 7;
    localparam int SINGLE_BIT  = 6;
    localparam int TOUT_BIT    = 5;
    localparam int CLK_LO      = 3;
    localparam int CAP_IE_BIT  = 2;
    localparam int TOUT_IE_BIT = 1;
    localparam int PIN_BIT     = 0;
    // ctl_common bit positions
    localparam int MODE_BIT    = 7;
    localparam int SEL_BIT     = 6;
    localparam int FN_LO       = 4;
    localparam int SUB_LO      = 2;
    localparam int INIT_A_BIT  = 1;
    localparam int INIT_B_BIT  = 0;

    // reset values and writable masks
    localparam logic [7:0] CTL_A8_RST     = 8'h00;
    localparam logic [7:0] CTL_COMMON_RST = 8'h00;
    localparam logic [7:0] CTL_B16_RST    = 8'h00;
    localparam logic [7:0] A8_WMASK       = 8'hc7;
    localparam logic [7:0] B16_WMASK      = 8'hdf;

    // two-bit codes
    localparam logic [1:0] FN_AND    = 2'h0;
    localparam logic [1:0] FN_OR     = 2'h1;
    localparam logic [1:0] FN_NOR    = 2'h2;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] SUB_PP    = 2'h1;
    localparam logic [1:0] SUB_B0    = 2'h2;
    localparam logic [1:0] SUB_B1    = 2'h3;
    localparam logic [1:0] FILT_4    = 2'h1;
    localparam logic [1:0] FILT_8    = 2'h2;
    localparam logic [1:0] CODE_RSV  = 2'h3;
    localparam logic [1:0] DIV_2     = 2'h1;
    localparam logic [1:0] DIV_4     = 2'h2;

    // glitch filter lengths in clock ticks
    localparam logic [3:0] FILT_4_TICKS = 4'h4;
    localparam logic [3:0] FILT_8_TICKS = 4'h8;
    localparam logic [3:0] FILT_0_TICKS = 4'h1;
endpackage

// File: verilog/dct_top.sv
/*
 * Control logic for an 8-bit and a 16-bit counter/timer sharing a common
 * control register: transmit waveform generation and demodulation capture.
 * Assumes a simple register port (strobes, read data one cycle later) and
 * pin inputs synchronous to clock_i.
 */
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module dct_top (
    input  wire logic                       clock_i,
    input  wire logic                       reset_n_i,
    input  wire logic [dct_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [dct_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                       wr_i,
    input  wire logic                       rd_i,
    output logic      [dct_pkg::DATA_W-1:0] rdata_o,
    input  wire logic                       in_primary_i,
    input  wire logic                       in_secondary_i,
    input  wire logic                       port_alt_a_i,
    input  wire logic                       port_alt_b_i,
    input  wire logic                       port_combined_i,
    output logic                            pin_alt_a_o,
    output logic                            pin_alt_b_o,
    output logic                            pin_combined_o,
    output logic                            irq_a8_o,
    output logic                            irq_b16_o,
    output logic                            ext_irq_two_o
);
    import dct_pkg::*;

    logic [7:0]  ctl_a8, ctl_common, ctl_b16;
    logic [7:0]  load_a8, load_lo, load_hi;
    logic [7:0]  cap_low, cap_high;
    logic [15:0] cap_b16;
    logic [7:0]  a8_cnt;
    logic [15:0] b16_cnt;
    logic        out_a, out_b, armed;
    logic        flag_rise, flag_fall;
    logic [1:0]  eff_edge, eff_filt;
    logic [2:0]  pre;

    logic [7:0]  next_ctl_a8, next_ctl_common, next_ctl_b16;
    logic [7:0]  next_load_a8, next_load_lo, next_load_hi;
    logic [7:0]  next_cap_low, next_cap_high;
    logic [15:0] next_cap_b16;
    logic [7:0]  next_a8_cnt;
    logic [15:0] next_b16_cnt;
    logic        next_out_a, next_out_b, next_armed;
    logic        next_flag_rise, next_flag_fall;
    logic [1:0]  next_eff_edge, next_eff_filt;
    logic [2:0]  next_pre;

    logic        next_pin_a, next_pin_b, next_pin_c;
    logic        next_irq_a8, next_irq_b16, next_ext_irq;
    logic [7:0]  next_rdata;

    logic        mode, single_b16, single_a8;
    logic        wr_a8, wr_common, wr_b16;
    logic        tick_b16, din, rise, fall, edge_hit;
    logic        a8_tout, b16_tout, b16_cap, a8_cap;
    logic        out_b_eff, combined;
    logic [1:0]  sub, fn;

    assign mode       = ctl_common[MODE_BIT];
    assign sub        = ctl_common[SUB_LO +: 2];
    assign fn         = ctl_common[FN_LO +: 2];
    assign single_b16 = ctl_b16[SINGLE_BIT];
    assign single_a8  = ctl_a8[SINGLE_BIT];
    assign wr_a8      = wr_i && (addr_i == ADDR_CTL_A8);
    assign wr_common  = wr_i && (addr_i == ADDR_CTL_COMMON);
    assign wr_b16     = wr_i && (addr_i == ADDR_CTL_B16);

    assign din = ctl_common[SEL_BIT] ? in_secondary_i : in_primary_i;

    // filtered edges of the selected input
    dct_edge u_edge (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .din_i     (din),
        .filt_i    (eff_filt),
        .rise_o    (rise),
        .fall_o    (fall)
    );

    always_comb begin
        if (eff_edge == EDGE_FALL) begin
            edge_hit = mode && fall;
        end else if (eff_edge == EDGE_RISE) begin
            edge_hit = mode && rise;
        end else begin
            edge_hit = mode && (rise || fall);
        end
    end

    always_comb begin
        next_pre = pre + 3'h1;
        case (ctl_b16[CLK_LO +: 2])
            2'h0:    tick_b16 = 1'b1;
            DIV_2:   tick_b16 = pre[0];
            DIV_4:   tick_b16 = &pre[1:0];
            default: tick_b16 = &pre;
        endcase
    end

    // counters, captures and control registers
    always_comb begin
        next_ctl_a8     = ctl_a8;
        next_ctl_common = ctl_common;
        next_ctl_b16    = ctl_b16;
        next_load_a8    = load_a8;
        next_load_lo    = load_lo;
        next_load_hi    = load_hi;
        next_cap_low    = cap_low;
        next_cap_high   = cap_high;
        next_cap_b16    = cap_b16;
        next_a8_cnt     = a8_cnt;
        next_b16_cnt    = b16_cnt;
        next_out_a      = out_a;
        next_out_b      = out_b;
        next_armed      = armed;
        next_eff_edge   = eff_edge;
        next_eff_filt   = eff_filt;
        a8_tout         = 1'b0;
        b16_tout        = 1'b0;
        b16_cap         = 1'b0;
        a8_cap          = 1'b0;

        // timer_a8 counts on every clock
        if (ctl_a8[RUN_BIT]) begin
            if (a8_cnt == 8'h00) begin
                a8_tout = 1'b1;
                if (!mode) begin
                    next_out_a = ~out_a;
                end
                if (single_a8) begin
                    next_ctl_a8[RUN_BIT] = 1'b0;
                end else begin
                    next_a8_cnt = load_a8;
                end
            end else begin
                next_a8_cnt = a8_cnt - 8'h01;
            end
        end

        // timer_b16 counts on the divided tick
        if (ctl_b16[RUN_BIT] && tick_b16) begin
            if (b16_cnt == 16'h0000) begin
                b16_tout = 1'b1;
                if (!mode) begin
                    next_out_b = ~out_b;
                    if (single_b16) begin
                        next_ctl_b16[RUN_BIT] = 1'b0;
                    end else begin
                        next_b16_cnt = {load_hi, load_lo};
                    end
                end else begin
                    next_b16_cnt = 16'hffff;
                end
            end else begin
                next_b16_cnt = b16_cnt - 16'h0001;
            end
        end

        if (!mode && sub == SUB_PP) begin
            if (a8_tout && single_a8) begin
                next_ctl_b16[RUN_BIT] = 1'b1;
                next_b16_cnt          = {load_hi, load_lo};
                next_out_b            = ctl_common[INIT_B_BIT];
            end
            if (b16_tout && single_b16) begin
                next_ctl_a8[RUN_BIT] = 1'b1;
                next_a8_cnt          = load_a8;
                next_out_a           = ctl_common[INIT_A_BIT];
            end
        end

        // timer_a8 captures its count on input edges
        if (mode && rise) begin
            next_cap_high = a8_cnt;
        end
        if (mode && fall) begin
            next_cap_low = a8_cnt;
        end
        a8_cap = edge_hit;

        if (mode) begin
            if (!single_b16) begin
                if (edge_hit) begin
                    next_cap_b16 = b16_cnt;
                    next_b16_cnt = {load_hi, load_lo};
                    b16_cap      = 1'b1;
                end
            end else if (armed && edge_hit) begin
                next_cap_b16 = b16_cnt;
                next_b16_cnt = {load_hi, load_lo};
                next_armed   = 1'b0;
                b16_cap      = 1'b1;
            end else if (a8_tout) begin
                next_cap_b16 = b16_cnt;
                b16_cap      = 1'b1;
            end
        end

        // register writes override the counters
        if (wr_a8) begin
            next_ctl_a8 = (wdata_i & A8_WMASK) |
                          (ctl_a8 & ~A8_WMASK);
            if (wdata_i[RUN_BIT] && !ctl_a8[RUN_BIT]) begin
                next_a8_cnt = load_a8;
                next_out_a  = ctl_common[INIT_A_BIT];
            end
        end
        if (wr_common) begin
            next_ctl_common[7:2] = wdata_i[7:2];
            if (!mode) begin
                next_ctl_common[1:0] = wdata_i[1:0];
            end
            if (wdata_i[FN_LO +: 2] != CODE_RSV) begin
                next_eff_edge = wdata_i[FN_LO +: 2];
            end
            if (wdata_i[SUB_LO +: 2] != CODE_RSV) begin
                next_eff_filt = wdata_i[SUB_LO +: 2];
            end
        end
        if (wr_b16) begin
            next_ctl_b16 = (wdata_i & B16_WMASK) |
                           (ctl_b16 & ~B16_WMASK);
            if (wdata_i[RUN_BIT] && !ctl_b16[RUN_BIT]) begin
                next_b16_cnt = {load_hi, load_lo};
                next_out_b   = ctl_common[INIT_B_BIT];
            end
            if (wdata_i[SINGLE_BIT] && !single_b16) begin
                next_armed = 1'b1;
            end
        end
        if (wr_i && addr_i == ADDR_LOAD_A8) begin
            next_load_a8 = wdata_i;
        end
        if (wr_i && addr_i == ADDR_LOAD_B16_LO) begin
            next_load_lo = wdata_i;
        end
        if (wr_i && addr_i == ADDR_LOAD_B16_HI) begin
            next_load_hi = wdata_i;
        end

        // sticky flags: a set in the clear cycle wins
        // timeout flag, write one clears
        next_ctl_b16[TOUT_BIT] = (ctl_b16[TOUT_BIT] &
            ~(wr_b16 & wdata_i[TOUT_BIT])) | b16_tout;
        next_ctl_a8[TOUT_BIT] = (ctl_a8[TOUT_BIT] &
            ~(wr_a8 & wdata_i[TOUT_BIT])) | a8_tout;
    end

    // edge flags, write one clears in demod
    always_comb begin
        next_flag_rise = (flag_rise & ~(wr_common & mode &
                          wdata_i[INIT_A_BIT])) | (mode & rise);
        next_flag_fall = (flag_fall & ~(wr_common & mode &
                          wdata_i[INIT_B_BIT])) | (mode & fall);
    end

    always_comb begin
        out_b_eff = out_b;
        if (!mode && sub == SUB_B0) begin
            out_b_eff = 1'b0;
        end else if (!mode && sub == SUB_B1) begin
            out_b_eff = 1'b1;
        end
        case (fn)
            FN_AND:  combined = out_a & out_b_eff;
            FN_OR:   combined = out_a | out_b_eff;
            FN_NOR:  combined = ~(out_a | out_b_eff);
            default: combined = ~(out_a & out_b_eff);
        endcase
    end

    // pin routing, interrupts and read data
    always_comb begin
        next_pin_a = ctl_a8[PIN_BIT] ? out_a : port_alt_a_i;
        next_pin_b = ctl_b16[PIN_BIT] ? out_b_eff : port_alt_b_i;
        next_pin_c = (!mode && ctl_common[SEL_BIT]) ? combined
                                                    : port_combined_i;
        next_irq_a8 = (a8_tout & ctl_a8[TOUT_IE_BIT]) |
                      (a8_cap & ctl_a8[CAP_IE_BIT]);
        next_irq_b16 = (b16_tout & ctl_b16[TOUT_IE_BIT]) |
                       (b16_cap & ctl_b16[CAP_IE_BIT]);
        // primary input also feeds external irq
        next_ext_irq = edge_hit & ~ctl_common[SEL_BIT];
        next_rdata = 8'h00;
        if (rd_i) begin
            case (addr_i)
                ADDR_CTL_A8:      next_rdata = ctl_a8;
                ADDR_CTL_COMMON:  next_rdata = mode ?
                    {ctl_common[7:2], flag_rise, flag_fall} : ctl_common;
                ADDR_CTL_B16:     next_rdata = ctl_b16;
                ADDR_LOAD_A8:     next_rdata = load_a8;
                ADDR_LOAD_B16_LO: next_rdata = load_lo;
                ADDR_LOAD_B16_HI: next_rdata = load_hi;
                ADDR_CAP_B16_LO:  next_rdata = cap_b16[7:0];
                ADDR_CAP_B16_HI:  next_rdata = cap_b16[15:8];
                ADDR_CAP_LOW:     next_rdata = cap_low;
                ADDR_CAP_HIGH:    next_rdata = cap_high;
                default:          next_rdata = 8'h00;
            endcase
        end
    end

    // state registers; reset clears every field
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctl_a8     <= CTL_A8_RST;
            ctl_common <= CTL_COMMON_RST;
            ctl_b16    <= CTL_B16_RST;
            load_a8    <= 8'h00;
            load_lo    <= 8'h00;
            load_hi    <= 8'h00;
            cap_low    <= 8'h00;
            cap_high   <= 8'h00;
            cap_b16    <= 16'h0000;
            a8_cnt     <= 8'h00;
            b16_cnt    <= 16'h0000;
            out_a      <= 1'b0;
            out_b      <= 1'b0;
            armed      <= 1'b0;
            flag_rise  <= 1'b0;
            flag_fall  <= 1'b0;
            eff_edge   <= 2'h0;
            eff_filt   <= 2'h0;
            pre        <= 3'h0;
        end else begin
            ctl_a8     <= next_ctl_a8;
            ctl_common <= next_ctl_common;
            ctl_b16    <= next_ctl_b16;
            load_a8    <= next_load_a8;
            load_lo    <= next_load_lo;
            load_hi    <= next_load_hi;
            cap_low    <= next_cap_low;
            cap_high   <= next_cap_high;
            cap_b16    <= next_cap_b16;
            a8_cnt     <= next_a8_cnt;
            b16_cnt    <= next_b16_cnt;
            out_a      <= next_out_a;
            out_b      <= next_out_b;
            armed      <= next_armed;
            flag_rise  <= next_flag_rise;
            flag_fall  <= next_flag_fall;
            eff_edge   <= next_eff_edge;
            eff_filt   <= next_eff_filt;
            pre        <= next_pre;
        end
    end

    // registered outputs, one cycle behind their cause
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o        <= 8'h00;
            pin_alt_a_o    <= 1'b0;
            pin_alt_b_o    <= 1'b0;
            pin_combined_o <= 1'b0;
            irq_a8_o       <= 1'b0;
            irq_b16_o      <= 1'b0;
            ext_irq_two_o  <= 1'b0;
        end else begin
            rdata_o        <= next_rdata;
            pin_alt_a_o    <= next_pin_a;
            pin_alt_b_o    <= next_pin_b;
            pin_combined_o <= next_pin_c;
            irq_a8_o       <= next_irq_a8;
            irq_b16_o      <= next_irq_b16;
            ext_irq_two_o  <= next_ext_irq;
        end
    end
endmodule
